// ===== include/fault_prot_pkg.sv
// Shared constants for the motor drive fault-protection block
package fault_prot_pkg;
    // Overload timer setting field width
    localparam int SETTING_W        = 3;
    // Timer charge and discharge currents, microamps
    localparam int CHARGE_UA        = 40;
    localparam int DISCHARGE_UA     = 10;
    // Counter steps per clock while charging / discharging (4:1)
    localparam int CHARGE_STEP      = CHARGE_UA / DISCHARGE_UA;
    localparam int DISCHARGE_STEP   = 1;
    // Overload counter width
    localparam int OL_CNT_W         = 16;
    // Base trip count, scaled by (setting + 1)
    localparam int OL_TRIP_BASE     = 4096;
    // Comparator thresholds in millivolts, kept for reference
    localparam int OL_THRESH_MV     = 1400;
    localparam int CYC_THRESH_MV    = 1500;
    localparam int SHORT_THRESH_MV  = 2500;
    localparam int SYS_OV_MV        = 18000;
    localparam int SYS_UV_MV        = 8000;
    localparam int REG_UV_MV        = 4000;
    localparam int MOT_OV_ON_MV     = 4500;
    localparam int MOT_OV_OFF_MV    = 4000;
    // Short-circuit pulse count that trips the latch (three to four)
    localparam int SHORT_PULSES     = 3;
    localparam int SHORT_CNT_W      = 2;
    // Number of motor drive outputs
    localparam int DRIVE_W          = 6;
    // Synchroniser stage count
    localparam int SYNC_STAGES      = 3;
endpackage

// ===== verilog/input_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module input_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Raw pin and filtered level
    input  wire logic pinIn,
    output logic      levelOut
);
    logic [2:0] stage_q;   // Synchroniser stages
    logic [2:0] stage_d;
    logic       level_q;   // Accepted level
    logic       level_d;

    // Shift in, accept a change once stages two and three agree
    always_comb begin
        stage_d = {stage_q[1:0], pinIn};
        level_d = level_q;
        if (stage_q[1] == stage_q[2]) begin
            level_d = stage_q[2];
        end
    end

    // Register stages
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= {3{RESET_VALUE}};
            level_q <= RESET_VALUE;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign levelOut = level_q;
endmodule // input_sync

// ===== verilog/overload_timer.sv
// Saturating up/down overload timer with programmable trip level
`timescale 1ns/1ps
module overload_timer #(
    parameter int CNT_W = fault_prot_pkg::OL_CNT_W
) (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               reset_n,
    // Control
    input  wire logic                               overloaded,
    input  wire logic                               clear,
    input  wire logic [fault_prot_pkg::SETTING_W-1:0] setting,
    // Result
    output logic                                    tripped
);
    logic [CNT_W-1:0] count_q;  // Timer level
    logic [CNT_W-1:0] count_d;
    logic [CNT_W:0]   trip;     // Trip level for this setting
    logic [CNT_W:0]   sum;

    // Count up 4 per clock while overloaded, down 1 otherwise
    always_comb begin
        trip = (CNT_W+1)'(fault_prot_pkg::OL_TRIP_BASE)
               * (CNT_W+1)'({1'b0, setting} + 4'h1);
        sum  = {1'b0, count_q} + (CNT_W+1)'(fault_prot_pkg::CHARGE_STEP);
        count_d = count_q;
        if (clear) begin
            count_d = '0;
        end else if (overloaded) begin
            count_d = (sum >= trip) ? CNT_W'(trip - 1'b1)
                                     : sum[CNT_W-1:0];
        end else if (count_q != '0) begin
            count_d = count_q - CNT_W'(fault_prot_pkg::DISCHARGE_STEP);
        end
        tripped = ({1'b0, count_q} == trip - 1'b1);
    end

    // Register level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule // overload_timer

// ===== verilog/motor_drive_fault_protection.sv
// Fault protection for a three-phase motor drive
`timescale 1ns/1ps
module motor_drive_fault_protection (
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    // Comparator flags from analogue front end
    input  wire logic                                 overloadCmp,
    input  wire logic                                 cycleLimitCmp,
    input  wire logic                                 shortCircuitCmp,
    input  wire logic                                 sysOverCmp,
    input  wire logic                                 sysUnderCmp,
    input  wire logic                                 regUnderCmp,
    input  wire logic                                 motorOverHiCmp,
    input  wire logic                                 motorOverLoCmp,
    input  wire logic                                 timerPinTripCmp,
    input  wire logic                                 timerPinGrounded,
    // Control
    input  wire logic                                 free_start_control,
    input  wire logic                                 useInternalTimer,
    input  wire logic [fault_prot_pkg::SETTING_W-1:0] overload_time_setting,
    input  wire logic                                 pwmPeriodStart,
    input  wire logic [fault_prot_pkg::DRIVE_W-1:0]   driveIn,
    // Outputs
    output logic [fault_prot_pkg::DRIVE_W-1:0]        driveOut,
    output logic                                      forceMinDuty,
    output logic                                      timerChargeOn,
    output logic                                      timerDischargeOn,
    output logic                                      overvoltage_discharge_out,
    output logic                                      faultLatched,
    output logic                                      selfReset
);
    ////////////////////////////////////////////////////////////////////////
    // Comparator synchronisation
    localparam int NFLAG = 11;
    logic [NFLAG-1:0] rawFlags;   // Raw comparator and pin levels
    logic [NFLAG-1:0] syncFlags;  // Filtered levels
    assign rawFlags = {free_start_control, timerPinGrounded,
                       timerPinTripCmp, motorOverLoCmp, motorOverHiCmp,
                       regUnderCmp, sysUnderCmp, sysOverCmp,
                       shortCircuitCmp, cycleLimitCmp, overloadCmp};

    // One synchroniser per flag
    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : gSync
            input_sync #(.RESET_VALUE(1'b0)) uSync (
                .clk      (clk),
                .reset_n  (reset_n),
                .pinIn    (rawFlags[gi]),
                .levelOut (syncFlags[gi])
            );
        end
    endgenerate

    logic overS, cycS, shortS, sysOvS, sysUvS, regUvS;
    logic motHiS, motLoS, pinTripS, pinGndS, freeS;
    assign overS    = syncFlags[0];   // Above 1.4V
    assign cycS     = syncFlags[1];   // Above 1.5V
    assign shortS   = syncFlags[2];
    assign sysOvS   = syncFlags[3];
    assign sysUvS   = syncFlags[4];
    assign regUvS   = syncFlags[5];
    assign motHiS   = syncFlags[6];
    assign motLoS   = syncFlags[7];
    assign pinTripS = syncFlags[8];
    assign pinGndS  = syncFlags[9];
    assign freeS    = syncFlags[10];

    ////////////////////////////////////////////////////////////////////////
    // Overload timer
    logic intTrip;    // Internal counter at trip level
    logic olTrip;     // Overload trip from selected source
    logic restart;    // Free high then low seen

    // Internal timer, cleared on restart
    overload_timer #(.CNT_W(fault_prot_pkg::OL_CNT_W)) uTimer (
        .clk        (clk),
        .reset_n    (reset_n),
        .overloaded (overS),
        .clear      (restart || !useInternalTimer),
        .setting    (overload_time_setting),
        .tripped    (intTrip)
    );

    // Source select, and disable the external source when pin grounded
    assign olTrip = useInternalTimer ? intTrip
                  : (pinTripS && !pinGndS);

    ////////////////////////////////////////////////////////////////////////
    // Latch state machine
    typedef enum logic [2:0] {
        RUN   = 3'h1,
        LATCH = 3'h2,
        FREED = 3'h4
    } latch_t;
    latch_t state_q, state_d;

    // Short-circuit pulse counter
    logic [fault_prot_pkg::SHORT_CNT_W-1:0] shortCnt_q, shortCnt_d;
    logic shortSeen_q, shortSeen_d;   // Short seen this PWM period
    logic shortTrip;

    // Count consecutive PWM periods with short-circuit level
    always_comb begin
        shortSeen_d = shortSeen_q | shortS;
        shortCnt_d  = shortCnt_q;
        if (pwmPeriodStart) begin
            shortSeen_d = shortS;
            if (shortSeen_q) begin
                if (shortCnt_q != fault_prot_pkg::SHORT_CNT_W'(
                        fault_prot_pkg::SHORT_PULSES)) begin
                    shortCnt_d = shortCnt_q + 1'b1;
                end
            end else begin
                shortCnt_d = '0;
            end
        end
        if (state_q != RUN) begin
            shortCnt_d  = '0;
            shortSeen_d = 1'b0;
        end
        shortTrip = (shortCnt_q == fault_prot_pkg::SHORT_CNT_W'(
                     fault_prot_pkg::SHORT_PULSES));
    end

    // Latch on trip, release on free high then low
    always_comb begin
        state_d = state_q;
        restart = 1'b0;
        case (state_q)
            RUN: begin
                if (olTrip || shortTrip) begin
                    state_d = LATCH;
                end
            end
            LATCH: begin
                if (freeS) begin
                    state_d = FREED;
                end
            end
            FREED: begin
                if (!freeS) begin
                    state_d = RUN;
                    restart = 1'b1;
                end
            end
            default: begin
                state_d = RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Motor supply over-voltage with hysteresis
    logic motOv_q, motOv_d;
    always_comb begin
        motOv_d = motOv_q;
        if (motHiS) begin
            motOv_d = 1'b1;
        end else if (!motLoS) begin
            motOv_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output computation
    logic [fault_prot_pkg::DRIVE_W-1:0] drive_d;
    logic driveOff, minDuty_d, chg_d, dis_d, overvoltage_discharge_out_d, uv_d;
    always_comb begin
        uv_d     = sysUvS;
        driveOff = (state_q != RUN) || sysOvS || sysUvS
                 || regUvS || motOv_q || freeS;
        drive_d  = driveOff ? '0 : driveIn;
        minDuty_d = cycS;
        chg_d    = overS && !pinGndS;
        dis_d    = !overS && !pinGndS;
        overvoltage_discharge_out_d   = motOv_q;
    end

    // Register all state and outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= RUN;
            shortCnt_q  <= '0;
            shortSeen_q <= 1'b0;
            motOv_q     <= 1'b0;
            driveOut    <= '0;
            forceMinDuty <= 1'b0;
            timerChargeOn <= 1'b0;
            timerDischargeOn <= 1'b0;
            overvoltage_discharge_out <= 1'b0;
            faultLatched <= 1'b0;
            selfReset   <= 1'b0;
        end else if (sysUvS) begin
            // Under-voltage holds the latch and short counter in reset with drive off
            state_q     <= RUN;
            shortCnt_q  <= '0;
            shortSeen_q <= 1'b0;
            motOv_q     <= motOv_d;
            driveOut    <= '0;
            forceMinDuty <= minDuty_d;
            timerChargeOn <= chg_d;
            timerDischargeOn <= dis_d;
            overvoltage_discharge_out <= overvoltage_discharge_out_d;
            faultLatched <= 1'b0;
            selfReset   <= uv_d;
        end else begin
            state_q     <= state_d;
            shortCnt_q  <= shortCnt_d;
            shortSeen_q <= shortSeen_d;
            motOv_q     <= motOv_d;
            driveOut    <= drive_d;
            forceMinDuty <= minDuty_d;
            timerChargeOn <= chg_d;
            timerDischargeOn <= dis_d;
            overvoltage_discharge_out <= overvoltage_discharge_out_d;
            faultLatched <= (state_d != RUN);
            selfReset   <= uv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_trip_latches: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == RUN && olTrip && !sysUvS) |=> faultLatched)
        else $error("overload trip did not latch");
    a_short_latches: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == RUN && shortTrip && !sysUvS) |=> faultLatched)
        else $error("short trip did not latch");
    a_latch_off: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q != RUN) |=> (driveOut == '0))
        else $error("drive active while latched");
    a_release_seq: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == LATCH && !freeS && !sysUvS) |=> (state_q == LATCH))
        else $error("latch released without free");
    a_min_duty: assert property (@(posedge clk) disable iff (!reset_n)
        cycS |=> forceMinDuty)
        else $error("cycle limit ignored");
    a_sys_ov_off: assert property (@(posedge clk) disable iff (!reset_n)
        sysOvS |=> (driveOut == '0))
        else $error("drive on in system over-voltage");
    a_sys_uv_off: assert property (@(posedge clk) disable iff (!reset_n)
        sysUvS |=> (driveOut == '0 && selfReset))
        else $error("under-voltage not handled");
    a_reg_uv_off: assert property (@(posedge clk) disable iff (!reset_n)
        regUvS |=> (driveOut == '0))
        else $error("drive on in regulator under-voltage");
    a_mot_ov_off: assert property (@(posedge clk) disable iff (!reset_n)
        motHiS |=> ##1 (driveOut == '0 && overvoltage_discharge_out))
        else $error("motor over-voltage not handled");
    a_mot_ov_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (!motHiS && !motLoS) |=> ##1 !overvoltage_discharge_out)
        else $error("discharge output stuck");
    a_charge_dir: assert property (@(posedge clk) disable iff (!reset_n)
        (overS && !pinGndS) |=> (timerChargeOn && !timerDischargeOn))
        else $error("timer not charging");

    c_overload: cover property (@(posedge clk) disable iff (!reset_n)
        state_q == RUN ##1 state_q == LATCH);
    c_restart: cover property (@(posedge clk) disable iff (!reset_n)
        state_q == FREED ##1 state_q == RUN);
    c_short: cover property (@(posedge clk) disable iff (!reset_n)
        shortTrip);
    c_mot_ov: cover property (@(posedge clk) disable iff (!reset_n)
        motOv_q ##1 !motOv_q);
endmodule // motor_drive_fault_protection

// ===== test/gate_stage_model.sv
// Power stage side model: timer capacitor and grounding strap
`timescale 1ns/1ps
module gate_stage_model #(
    parameter int TRIP_LEVEL = 6000 // Trip level in model charge steps
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Timer pin current sources from the block
    input  wire logic timerChargeOn,
    input  wire logic timerDischargeOn,
    // Bench strap that grounds the timer pin
    input  wire logic strapGround,
    // Timer pin comparators back to the block
    output logic      timerPinTripCmp,
    output logic      timerPinGrounded
);
    int capLevel; // Capacitor charge in steps

    ////////////////////////////////////////////////////////////////
    // Capacitor: 4 steps up charging, 1 step down discharging
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            capLevel <= 0;
        end else if (strapGround) begin
            capLevel <= 0; // Grounded pin never charges
        end else if (timerChargeOn) begin
            capLevel <= capLevel + 4;
        end else if (timerDischargeOn && capLevel > 0) begin
            capLevel <= capLevel - 1;
        end
    end

    // Comparator outputs
    assign timerPinTripCmp  = (capLevel >= TRIP_LEVEL);
    assign timerPinGrounded = strapGround;
endmodule // gate_stage_model

// ===== test/motor_drive_fault_protection_tb.sv
// Self-checking bench for the motor drive fault protection
`timescale 1ns/1ps
module motor_drive_fault_protection_tb;
    // Clock, reset and run bookkeeping
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    int         miscompares = 0;
    int         nCompared = 0;
    int         cycles = 0;
    // Stimulus
    logic       overloadCmp, cycleLimitCmp, shortCircuitCmp;
    logic       motorOverHiCmp, motorOverLoCmp, strapGround;
    logic [2:0] supplyFault; // {sysOver, sysUnder, regUnder}
    logic       free_start_control, useInternalTimer, pwmPeriodStart;
    logic [2:0] overload_time_setting;
    logic [5:0] driveIn;
    // Observed
    logic [5:0] driveOut;
    logic       forceMinDuty, timerChargeOn, timerDischargeOn;
    logic       overvoltage_discharge_out, faultLatched, selfReset;
    logic       timerPinTripCmp, timerPinGrounded;

    ////////////////////////////////////////////////////////////////
    // 250 MHz clock and timeout
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Block under test and power stage
    motor_drive_fault_protection motor_drive_fault_protection_inst (
        .clk(clk), .reset_n(reset_n),
        .overloadCmp(overloadCmp), .cycleLimitCmp(cycleLimitCmp),
        .shortCircuitCmp(shortCircuitCmp),
        .sysOverCmp(supplyFault[2]), .sysUnderCmp(supplyFault[1]),
        .regUnderCmp(supplyFault[0]),
        .motorOverHiCmp(motorOverHiCmp), .motorOverLoCmp(motorOverLoCmp),
        .timerPinTripCmp(timerPinTripCmp),
        .timerPinGrounded(timerPinGrounded),
        .free_start_control(free_start_control),
        .useInternalTimer(useInternalTimer),
        .overload_time_setting(overload_time_setting),
        .pwmPeriodStart(pwmPeriodStart), .driveIn(driveIn),
        .driveOut(driveOut), .forceMinDuty(forceMinDuty),
        .timerChargeOn(timerChargeOn), .timerDischargeOn(timerDischargeOn),
        .overvoltage_discharge_out(overvoltage_discharge_out),
        .faultLatched(faultLatched), .selfReset(selfReset));
    gate_stage_model #(.TRIP_LEVEL(6000)) gate_stage_model_inst (
        .clk(clk), .reset_n(reset_n), .timerChargeOn(timerChargeOn),
        .timerDischargeOn(timerDischargeOn), .strapGround(strapGround),
        .timerPinTripCmp(timerPinTripCmp),
        .timerPinGrounded(timerPinGrounded));

    ////////////////////////////////////////////////////////////////
    // Helpers
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task checkVec(input string what, input logic [5:0] exp,
                  input logic [5:0] got);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task checkBit(input string what, input logic exp, input logic got);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Wait for the latch under a bound
    task waitLatch(input int limit);
        int i;
        i = 0;
        while (faultLatched !== 1'b1 && i < limit) begin
            tick(1);
            i++;
        end
    endtask
    // Free high then low releases the latch
    task restart();
        free_start_control = 1'b1;
        tick(8);
        checkVec("driveOut free", 6'h00, driveOut);
        free_start_control = 1'b0;
        tick(8);
        checkVec("driveOut start", 6'h2A, driveOut);
        checkBit("faultLatched start", 1'b0, faultLatched);
    endtask
    // One PWM period with its start pulse
    task period();
        pwmPeriodStart = 1'b1;
        tick(1);
        pwmPeriodStart = 1'b0;
        tick(63);
    endtask
    task conclude();
        if (miscompares == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {overloadCmp, cycleLimitCmp, shortCircuitCmp} = 3'h0;
        {motorOverHiCmp, motorOverLoCmp, strapGround} = 3'h0;
        {free_start_control, useInternalTimer, pwmPeriodStart} = 3'h0;
        supplyFault = 3'h0;
        overload_time_setting = 3'h0;
        driveIn = 6'h2A;
        tick(12);
        checkVec("driveOut reset", 6'h00, driveOut);
        reset_n = 1'b1;
        tick(8);
        checkVec("driveOut healthy", 6'h2A, driveOut);
        // Supply faults, one at a time
        for (int k = 0; k < 3; k++) begin
            supplyFault = 3'h4 >> k;
            tick(2);
            checkVec("driveOut sync", 6'h2A, driveOut);
            tick(6);
            checkVec("driveOut supply", 6'h00, driveOut);
            checkBit("selfReset", supplyFault[1], selfReset);
            supplyFault = 3'h0;
            tick(8);
            checkVec("driveOut recover", 6'h2A, driveOut);
        end
        // Cycle-by-cycle limit
        cycleLimitCmp = 1'b1;
        tick(8);
        checkBit("forceMinDuty on", 1'b1, forceMinDuty);
        cycleLimitCmp = 1'b0;
        tick(8);
        checkBit("forceMinDuty off", 1'b0, forceMinDuty);
        // Motor over-voltage with hysteresis
        {motorOverHiCmp, motorOverLoCmp} = 2'h3;
        tick(8);
        checkVec("driveOut motor ov", 6'h00, driveOut);
        checkBit("discharge on", 1'b1, overvoltage_discharge_out);
        motorOverHiCmp = 1'b0;
        tick(8);
        checkVec("driveOut hyst", 6'h00, driveOut);
        checkBit("discharge hyst", 1'b1, overvoltage_discharge_out);
        motorOverLoCmp = 1'b0;
        tick(8);
        checkVec("driveOut motor ok", 6'h2A, driveOut);
        checkBit("discharge off", 1'b0, overvoltage_discharge_out);
        // Internal timer: 600 up, 400 down, then 2095/4 more to trip
        useInternalTimer = 1'b1;
        overloadCmp = 1'b1;
        tick(600);
        overloadCmp = 1'b0;
        tick(400);
        overloadCmp = 1'b1;
        tick(500);
        checkBit("internal early", 1'b0, faultLatched);
        waitLatch(60);
        checkBit("internal trip", 1'b1, faultLatched);
        overloadCmp = 1'b0;
        restart();
        // Setting one doubles the trip level to 8192
        overload_time_setting = 3'h1;
        overloadCmp = 1'b1;
        tick(1500);
        checkBit("setting early", 1'b0, faultLatched);
        waitLatch(600);
        checkBit("setting trip", 1'b1, faultLatched);
        overloadCmp = 1'b0;
        restart();
        overload_time_setting = 3'h0;
        // Ground the charged pin before leaving internal mode
        strapGround = 1'b1;
        tick(8);
        useInternalTimer = 1'b0;
        // Grounded timer pin never trips
        overloadCmp = 1'b1;
        tick(2000);
        checkBit("grounded", 1'b0, faultLatched);
        overloadCmp = 1'b0;
        strapGround = 1'b0;
        tick(8);
        // External capacitor timer
        overloadCmp = 1'b1;
        tick(8);
        checkBit("charge on", 1'b1, timerChargeOn);
        checkBit("latch early", 1'b0, faultLatched);
        waitLatch(1600);
        checkBit("cap trip", 1'b1, faultLatched);
        overloadCmp = 1'b0;
        tick(8);
        checkBit("discharge src", 1'b1, timerDischargeOn);
        checkBit("charge off", 1'b0, timerChargeOn);
        checkVec("driveOut held", 6'h00, driveOut);
        // Let the capacitor bleed below trip, else restart re-trips
        tick(48);
        restart();
        // Short circuit over three to four periods
        shortCircuitCmp = 1'b1;
        tick(8);
        period();
        period();
        checkBit("short two", 1'b0, faultLatched);
        for (int p = 0; p < 2 && faultLatched !== 1'b1; p++)
            period();
        checkBit("short trip", 1'b1, faultLatched);
        shortCircuitCmp = 1'b0;
        tick(8);
        checkVec("driveOut short", 6'h00, driveOut);
        restart();
        conclude();
    end
endmodule // motor_drive_fault_protection_tb
